/* File: common/frps_pkg.sv */
// Constants, register map, field layout and types of the flash row
// program sequencer.
// Assumes a 200 MHz system clock and an AXI4-Lite bus with 8-bit addresses.
package frps_pkg;

	// Clock period and the self-timed operation lengths.
	localparam int unsigned CLK_NS     = 5;
	localparam int unsigned T_ROW_NS   = 1_480_000;
	localparam int unsigned T_PAGE_NS  = 2_000_000;
	localparam int unsigned T_WORD_NS  = 50_000;
	localparam int unsigned CYC_ROW    = (T_ROW_NS + CLK_NS - 1) / CLK_NS;
	localparam int unsigned CYC_PAGE   = (T_PAGE_NS + CLK_NS - 1) / CLK_NS;
	localparam int unsigned CYC_WORD   = (T_WORD_NS + CLK_NS - 1) / CLK_NS;
	localparam int          TMR_W      = 24;
	localparam logic [23:0] TMR_LAST   = 24'h00_0001;

	// Register byte offsets.
	localparam logic [7:0]  OFS_CTRL   = 8'h00;
	localparam logic [7:0]  OFS_KEY    = 8'h04;
	localparam logic [7:0]  OFS_PAGE   = 8'h08;
	localparam logic [7:0]  OFS_PTR    = 8'h0C;
	localparam logic [7:0]  OFS_TLO    = 8'h10;
	localparam logic [7:0]  OFS_THI    = 8'h14;
	localparam logic [7:0]  OFS_STAT   = 8'h18;

	// One-hot register select positions.
	localparam int          SEL_W      = 7;
	localparam int          SEL_CTRL   = 0;
	localparam int          SEL_KEY    = 1;
	localparam int          SEL_PAGE   = 2;
	localparam int          SEL_PTR    = 3;
	localparam int          SEL_TLO    = 4;
	localparam int          SEL_THI    = 5;
	localparam int          SEL_STAT   = 6;

	// Control register fields and reset value.
	localparam int          B_START    = 15;
	localparam int          B_PROGRAM_WRITE_ENABLE     = 14;
	localparam int          B_ERR      = 13;
	localparam int          B_ERASE    = 6;
	localparam logic [15:0] CTRL_RST   = 16'h0000;

	// Operation codes and unlock keys.
	localparam logic [3:0]  OP_PAGE    = 4'h2;
	localparam logic [3:0]  OP_ROW     = 4'h1;
	localparam logic [3:0]  OP_WORD    = 4'h3;
	localparam logic [7:0]  KEY_FIRST  = 8'h55;
	localparam logic [7:0]  KEY_SECOND = 8'hAA;

	// Row and page geometry in program addresses.
	localparam logic [5:0]  IDX_LAST   = 6'h3F;
	localparam logic [23:0] ROW_MASK   = 24'hFF_FF80;
	localparam logic [23:0] PAGE_MASK  = 24'hFF_FC00;

	// Bus answers.
	localparam logic [1:0]  RESP_OKAY  = 2'h0;
	localparam logic [1:0]  RESP_SLV   = 2'h2;

	typedef enum logic [2:0] {
		UK_NONE  = 3'b001,
		UK_HALF  = 3'b010,
		UK_ARMED = 3'b100
	} frps_unlock_t;

	typedef enum logic [2:0] {
		SQ_IDLE = 3'b001,
		SQ_FEED = 3'b010,
		SQ_BURN = 3'b100
	} frps_seq_t;

	// Maps a byte address onto a one-hot register select.
	function automatic logic [SEL_W-1:0] frps_decode(input logic [7:0] a);
		frps_decode = '0;
		if (a == OFS_CTRL) begin
			frps_decode[SEL_CTRL] = 1'b1;
		end else if (a == OFS_KEY) begin
			frps_decode[SEL_KEY] = 1'b1;
		end else if (a == OFS_PAGE) begin
			frps_decode[SEL_PAGE] = 1'b1;
		end else if (a == OFS_PTR) begin
			frps_decode[SEL_PTR] = 1'b1;
		end else if (a == OFS_TLO) begin
			frps_decode[SEL_TLO] = 1'b1;
		end else if (a == OFS_THI) begin
			frps_decode[SEL_THI] = 1'b1;
		end else if (a == OFS_STAT) begin
			frps_decode[SEL_STAT] = 1'b1;
		end
	endfunction : frps_decode

	// Merges the enabled low byte lanes of a write into an old value.
	function automatic logic [15:0] frps_merge(input logic [15:0] old_v,
			input logic [15:0] new_v, input logic [3:0] strb);
		frps_merge = old_v;
		if (strb[0]) begin
			frps_merge[7:0] = new_v[7:0];
		end
		if (strb[1]) begin
			frps_merge[15:8] = new_v[15:8];
		end
	endfunction : frps_merge

endpackage : frps_pkg

/* File: hw/frps_row_buffer.sv */
// Holding buffer of 64 instruction words, 24 bits each.
// Assumes low word and high byte writes arrive as separate strobes.
`timescale 1ns/1ps
module frps_row_buffer (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        wr_lo_i,
	input  wire logic        wr_hi_i,
	input  wire logic [5:0]  wr_idx_i,
	input  wire logic [15:0] wr_lo_data_i,
	input  wire logic [7:0]  wr_hi_data_i,
	input  wire logic [5:0]  rd_idx_i,
	output logic      [23:0] rd_data_o
);

	logic [23:0] mem [64];

	// Each half of an entry is written by its own table write.
	always_ff @(posedge clk_i) begin
		if (wr_lo_i) begin
			mem[wr_idx_i][15:0] <= wr_lo_data_i;
		end
		if (wr_hi_i) begin
			mem[wr_idx_i][23:16] <= wr_hi_data_i;
		end
	end

	// Read data leave through a register, one cycle after the index.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			rd_data_o <= '0;
		end else begin
			rd_data_o <= mem[rd_idx_i];
		end
	end

endmodule : frps_row_buffer

/* File: hw/frps_op_timer.sv */
// Down counter that times one erase or program cycle.
// Assumes the loaded count is at least one.
`timescale 1ns/1ps
module frps_op_timer (
	input  wire logic                        clk_i,
	input  wire logic                        rst_i,
	input  wire logic                        load_i,
	input  wire logic [frps_pkg::TMR_W-1:0]  cycles_i,
	output logic                             done_o
);

	logic [frps_pkg::TMR_W-1:0] count_reg;

	// Loading restarts the count; otherwise it runs down to zero.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			count_reg <= '0;
		end else if (load_i) begin
			count_reg <= cycles_i;
		end else if (count_reg != '0) begin
			count_reg <= count_reg - frps_pkg::TMR_LAST;
		end
	end

	// The done pulse marks the edge on which the count reaches zero.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			done_o <= 1'b0;
		end else begin
			done_o <= !load_i && (count_reg == frps_pkg::TMR_LAST);
		end
	end

endmodule : frps_op_timer

/* File: hw/frps_sequencer.sv */
// Flash row program sequencer: control, unlock, holding buffer loading
// and the self-timed erase and program cycles, behind AXI4-Lite.
// Assumes the core stops issuing bus writes while the stall output is high.
// Functional notes
// - Op code 0010 with erase and write enable set performs a page erase.
// - No erase or program starts unless keys 0x55 then 0xAA were written.
// - Setting the start bit after unlock runs the cycle and stalls the core.
// - Hardware clears the start bit when the cycle has finished.
// - Op code 0001 with erase clear and write enable set programs a row.
// - Only the first key followed by the second key, with no other key or control write between, unlocks.
// - An improper start attempt sets the sequence error flag.
// - With write enable clear no erase or program is ever performed.
// - Op code 0011 with erase clear programs a single instruction word.
`timescale 1ns/1ps
module frps_sequencer #(
	parameter int unsigned PAGE_CYCLES = frps_pkg::CYC_PAGE,
	parameter int unsigned ROW_CYCLES  = frps_pkg::CYC_ROW,
	parameter int unsigned WORD_CYCLES = frps_pkg::CYC_WORD
) (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic [7:0]  s_axi_awaddr_i,
	input  wire logic        s_axi_awvalid_i,
	output logic             s_axi_awready_o,
	input  wire logic [31:0] s_axi_wdata_i,
	input  wire logic [3:0]  s_axi_wstrb_i,
	input  wire logic        s_axi_wvalid_i,
	output logic             s_axi_wready_o,
	output logic [1:0]       s_axi_bresp_o,
	output logic             s_axi_bvalid_o,
	input  wire logic        s_axi_bready_i,
	input  wire logic [7:0]  s_axi_araddr_i,
	input  wire logic        s_axi_arvalid_i,
	output logic             s_axi_arready_o,
	output logic [31:0]      s_axi_rdata_o,
	output logic [1:0]       s_axi_rresp_o,
	output logic             s_axi_rvalid_o,
	input  wire logic        s_axi_rready_i,
	output logic             flash_erase_o,
	output logic             flash_prog_o,
	output logic             flash_wvalid_o,
	output logic [23:0]      flash_addr_o,
	output logic [23:0]      flash_data_o,
	output logic             core_stall_o
);

	// Local copy of the timer width so that size casts stay short.
	localparam int TMR_W = frps_pkg::TMR_W;

	logic                      aw_have_reg;
	logic                      w_have_reg;
	logic [7:0]                awaddr_reg;
	logic [15:0]               wdata_reg;
	logic [3:0]                wstrb_reg;
	logic [frps_pkg::SEL_W-1:0] sel_w;
	logic                      wr_en;
	logic                      start_reg;
	logic                      program_write_enable_reg;
	logic                      err_reg;
	logic                      erase_reg;
	logic [3:0]                op_reg;
	logic [15:0]               ctrl_view;
	logic [15:0]               ctrl_new;
	logic                      ctrl_wr;
	logic                      key_wr;
	logic                      start_req;
	logic                      is_page;
	logic                      is_row;
	logic                      is_word;
	logic                      launch;
	logic                      bad;
	frps_pkg::frps_unlock_t    ukey_reg;
	logic [7:0]                page_reg;
	logic [15:0]               page_new;
	logic [15:0]               ptr_reg;
	logic [23:0]               tgt_reg;
	logic                      tlo_wr;
	logic                      thi_wr;
	frps_pkg::frps_seq_t       seq_reg;
	logic                      word_mode_reg;
	logic [5:0]                idx_reg;
	logic [5:0]                idx_d1_reg;
	logic                      v1_reg;
	logic [23:0]               base_reg;
	logic                      feed_last;
	logic                      tmr_load;
	logic [frps_pkg::TMR_W-1:0] tmr_cycles;
	logic                      tmr_done;
	logic [23:0]               buf_rdata;
	logic [frps_pkg::SEL_W-1:0] sel_r;

	// Write address and data are taken independently and held.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			aw_have_reg     <= 1'b0;
			w_have_reg      <= 1'b0;
			awaddr_reg      <= '0;
			wdata_reg       <= '0;
			wstrb_reg       <= '0;
			s_axi_awready_o <= 1'b1;
			s_axi_wready_o  <= 1'b1;
			s_axi_bvalid_o  <= 1'b0;
			s_axi_bresp_o   <= frps_pkg::RESP_OKAY;
		end else begin
			if (s_axi_awvalid_i && s_axi_awready_o) begin
				aw_have_reg     <= 1'b1;
				awaddr_reg      <= s_axi_awaddr_i;
				s_axi_awready_o <= 1'b0;
			end
			if (s_axi_wvalid_i && s_axi_wready_o) begin
				w_have_reg     <= 1'b1;
				wdata_reg      <= s_axi_wdata_i[15:0];
				wstrb_reg      <= s_axi_wstrb_i;
				s_axi_wready_o <= 1'b0;
			end
			if (wr_en) begin
				aw_have_reg    <= 1'b0;
				w_have_reg     <= 1'b0;
				s_axi_bvalid_o <= 1'b1;
				s_axi_bresp_o  <= (sel_w == '0) ? frps_pkg::RESP_SLV
					: frps_pkg::RESP_OKAY;
			end
			if (s_axi_bvalid_o && s_axi_bready_i) begin
				s_axi_bvalid_o  <= 1'b0;
				s_axi_awready_o <= 1'b1;
				s_axi_wready_o  <= 1'b1;
			end
		end
	end

	// Write decode and the control fields as the write would leave them.
	assign wr_en     = aw_have_reg && w_have_reg && !s_axi_bvalid_o;
	assign sel_w     = frps_pkg::frps_decode(awaddr_reg);
	assign ctrl_view = {start_reg, program_write_enable_reg, err_reg, 6'h00, erase_reg,
		2'h0, op_reg};
	assign ctrl_new  = frps_pkg::frps_merge(ctrl_view, wdata_reg, wstrb_reg);
	assign page_new  = frps_pkg::frps_merge({8'h00, page_reg}, wdata_reg,
		wstrb_reg);
	assign ctrl_wr   = wr_en && sel_w[frps_pkg::SEL_CTRL];
	assign key_wr    = wr_en && sel_w[frps_pkg::SEL_KEY] && wstrb_reg[0];
	assign tlo_wr    = wr_en && sel_w[frps_pkg::SEL_TLO] && !start_reg;
	assign thi_wr    = wr_en && sel_w[frps_pkg::SEL_THI] && !start_reg;
	assign start_req = ctrl_wr && ctrl_new[frps_pkg::B_START] && !start_reg;

	assign is_page = ctrl_new[frps_pkg::B_ERASE]
		&& (ctrl_new[3:0] == frps_pkg::OP_PAGE);
	assign is_row  = !ctrl_new[frps_pkg::B_ERASE]
		&& (ctrl_new[3:0] == frps_pkg::OP_ROW);
	assign is_word = !ctrl_new[frps_pkg::B_ERASE]
		&& (ctrl_new[3:0] == frps_pkg::OP_WORD);

	// launch only when armed and write enabled
	assign launch = start_req && (ukey_reg == frps_pkg::UK_ARMED)
		&& ctrl_new[frps_pkg::B_PROGRAM_WRITE_ENABLE] && (is_page || is_row || is_word);
	assign bad    = start_req && !launch;

	// Control fields change only while no cycle is running.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			program_write_enable_reg  <= frps_pkg::CTRL_RST[frps_pkg::B_PROGRAM_WRITE_ENABLE];
			erase_reg <= frps_pkg::CTRL_RST[frps_pkg::B_ERASE];
			op_reg    <= frps_pkg::CTRL_RST[3:0];
		end else if (ctrl_wr && !start_reg) begin
			program_write_enable_reg  <= ctrl_new[frps_pkg::B_PROGRAM_WRITE_ENABLE];
			erase_reg <= ctrl_new[frps_pkg::B_ERASE];
			op_reg    <= ctrl_new[3:0];
		end
	end

	// error flag, a new error wins over a software clear
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			err_reg <= frps_pkg::CTRL_RST[frps_pkg::B_ERR];
		end else if (bad) begin
			err_reg <= 1'b1;
		end else if (ctrl_wr && !start_reg) begin
			err_reg <= ctrl_new[frps_pkg::B_ERR];
		end
	end

	// unlock tracker, any other key write or a control write drops a half unlock
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			ukey_reg <= frps_pkg::UK_NONE;
		end else if (key_wr) begin
			if (wdata_reg[7:0] == frps_pkg::KEY_FIRST) begin
				ukey_reg <= frps_pkg::UK_HALF;
			end else if (wdata_reg[7:0] == frps_pkg::KEY_SECOND
					&& ukey_reg == frps_pkg::UK_HALF) begin
				ukey_reg <= frps_pkg::UK_ARMED;
			end else begin
				ukey_reg <= frps_pkg::UK_NONE;
			end
		end else if (ctrl_wr) begin
			ukey_reg <= frps_pkg::UK_NONE;
		end
	end

	// Table page, pointer and the address latched by a table write.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			page_reg <= '0;
			ptr_reg  <= '0;
			tgt_reg  <= '0;
		end else begin
			if (wr_en && sel_w[frps_pkg::SEL_PAGE]) begin
				page_reg <= page_new[7:0];
			end
			if (wr_en && sel_w[frps_pkg::SEL_PTR]) begin
				ptr_reg <= frps_pkg::frps_merge(ptr_reg, wdata_reg,
					wstrb_reg);
			end
			if (tlo_wr || thi_wr) begin
				tgt_reg <= {page_reg, ptr_reg};
			end
		end
	end

	// cycle sequencer, start bit set on launch, cleared at end
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			seq_reg       <= frps_pkg::SQ_IDLE;
			start_reg     <= frps_pkg::CTRL_RST[frps_pkg::B_START];
			word_mode_reg <= 1'b0;
			idx_reg       <= '0;
			base_reg      <= '0;
		end else begin
			case (seq_reg)
				frps_pkg::SQ_IDLE: begin
					if (launch) begin
						start_reg     <= 1'b1;
						word_mode_reg <= is_word;
						idx_reg       <= is_word ? tgt_reg[6:1] : 6'h00;
						base_reg      <= tgt_reg & frps_pkg::ROW_MASK;
						seq_reg       <= is_page ? frps_pkg::SQ_BURN
							: frps_pkg::SQ_FEED;
					end
				end
				frps_pkg::SQ_FEED: begin
					if (feed_last) begin
						seq_reg <= frps_pkg::SQ_BURN;
					end else begin
						idx_reg <= idx_reg + 6'h01;
					end
				end
				frps_pkg::SQ_BURN: begin
					if (tmr_done) begin
						start_reg <= 1'b0;
						seq_reg   <= frps_pkg::SQ_IDLE;
					end
				end
				default: begin
					seq_reg <= frps_pkg::SQ_IDLE;
				end
			endcase
		end
	end

	// The timer starts as the last buffer index is read, one cycle before that word reaches the array; a page erase starts it at launch.
	assign feed_last  = word_mode_reg || (idx_reg == frps_pkg::IDX_LAST);
	assign tmr_load   = (launch && is_page)
		|| (seq_reg == frps_pkg::SQ_FEED && feed_last);
	assign tmr_cycles = (seq_reg == frps_pkg::SQ_IDLE) ? TMR_W'(PAGE_CYCLES)
		: word_mode_reg ? TMR_W'(WORD_CYCLES) : TMR_W'(ROW_CYCLES);

	frps_op_timer u_timer (
		.clk_i    (clk_i),
		.rst_i    (rst_i),
		.load_i   (tmr_load),
		.cycles_i (tmr_cycles),
		.done_o   (tmr_done)
	);

	frps_row_buffer u_buffer (
		.clk_i        (clk_i),
		.rst_i        (rst_i),
		.wr_lo_i      (tlo_wr),
		.wr_hi_i      (thi_wr),
		.wr_idx_i     (ptr_reg[6:1]),
		.wr_lo_data_i (wdata_reg),
		.wr_hi_data_i (wdata_reg[7:0]),
		.rd_idx_i     (idx_reg),
		.rd_data_o    (buf_rdata)
	);

	// Buffer read pipeline, aligned with the registered read data.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			v1_reg     <= 1'b0;
			idx_d1_reg <= '0;
		end else begin
			v1_reg     <= (seq_reg == frps_pkg::SQ_FEED);
			idx_d1_reg <= idx_reg;
		end
	end

	// array strobes, each word with its address
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			flash_erase_o  <= 1'b0;
			flash_prog_o   <= 1'b0;
			flash_wvalid_o <= 1'b0;
			flash_addr_o   <= '0;
			flash_data_o   <= '0;
		end else begin
			flash_wvalid_o <= v1_reg;
			if (launch) begin
				flash_erase_o <= is_page;
				flash_prog_o  <= !is_page;
				flash_addr_o  <= tgt_reg & frps_pkg::PAGE_MASK;
			end else if (seq_reg == frps_pkg::SQ_BURN && tmr_done) begin
				flash_erase_o <= 1'b0;
				flash_prog_o  <= 1'b0;
			end
			if (v1_reg) begin
				flash_data_o <= buf_rdata;
				flash_addr_o <= base_reg | {17'h0_0000, idx_d1_reg, 1'b0};
			end
		end
	end

	// the core is stalled exactly while the start bit is set
	assign core_stall_o = start_reg;

	// Read channel answers one cycle after the address is taken.
	assign sel_r = frps_pkg::frps_decode(s_axi_araddr_i);
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			s_axi_arready_o <= 1'b1;
			s_axi_rvalid_o  <= 1'b0;
			s_axi_rdata_o   <= '0;
			s_axi_rresp_o   <= frps_pkg::RESP_OKAY;
		end else if (s_axi_arvalid_i && s_axi_arready_o) begin
			s_axi_arready_o <= 1'b0;
			s_axi_rvalid_o  <= 1'b1;
			s_axi_rresp_o   <= frps_pkg::RESP_OKAY;
			if (sel_r[frps_pkg::SEL_CTRL]) begin
				s_axi_rdata_o <= {16'h0000, ctrl_view};
			end else if (sel_r[frps_pkg::SEL_PAGE]) begin
				s_axi_rdata_o <= {24'h00_0000, page_reg};
			end else if (sel_r[frps_pkg::SEL_PTR]) begin
				s_axi_rdata_o <= {16'h0000, ptr_reg};
			end else if (sel_r[frps_pkg::SEL_STAT]) begin
				s_axi_rdata_o <= {28'h000_0000, v1_reg,
					ukey_reg == frps_pkg::UK_HALF,
					ukey_reg == frps_pkg::UK_ARMED, start_reg};
			end else begin
				s_axi_rdata_o <= '0;
				if (sel_r == '0) begin
					s_axi_rresp_o <= frps_pkg::RESP_SLV;
				end
			end
		end else if (s_axi_rvalid_o && s_axi_rready_i) begin
			s_axi_rvalid_o  <= 1'b0;
			s_axi_arready_o <= 1'b1;
		end
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	sequence s_feed8;
		flash_wvalid_o [*8];
	endsequence

	sequence s_word_once;
		flash_wvalid_o ##1 !flash_wvalid_o [*4];
	endsequence

	chk_erase_start: assert property (
		launch && is_page |=> flash_erase_o && !flash_prog_o
			&& core_stall_o && !flash_wvalid_o [*4])
		else $error("Page erase did not start cleanly.");
	chk_unlock_need: assert property (
		$rose(start_reg) |-> $past(ukey_reg == frps_pkg::UK_ARMED))
		else $error("Cycle started without unlock.");
	chk_stall_start: assert property (
		$rose(core_stall_o) |-> $past(ctrl_wr && ctrl_new[frps_pkg::B_START]))
		else $error("Stall rose without a start write.");
	chk_start_clear: assert property (
		seq_reg == frps_pkg::SQ_BURN && tmr_done |=> !start_reg
			&& !flash_prog_o && !flash_erase_o)
		else $error("Start bit not cleared at cycle end.");
	chk_row_feed: assert property (
		launch && is_row |-> ##3 s_feed8)
		else $error("Row program did not stream the buffer.");
	chk_key_pair: assert property (
		$rose(ukey_reg == frps_pkg::UK_ARMED) |->
			$past(ukey_reg == frps_pkg::UK_HALF)
			&& $past(wdata_reg[7:0] == frps_pkg::KEY_SECOND))
		else $error("Unlock without the key pair.");
	chk_seq_error: assert property (
		bad |=> err_reg && !start_reg)
		else $error("Improper start did not flag an error.");
	chk_program_write_enable_block: assert property (
		start_req && !ctrl_new[frps_pkg::B_PROGRAM_WRITE_ENABLE] |=> !start_reg
			##1 !flash_prog_o && !flash_erase_o)
		else $error("Operation ran with write enable clear.");
	chk_word_single: assert property (
		launch && is_word |-> ##3 s_word_once)
		else $error("Word program did not send exactly one word.");
	chk_key_drop: assert property (
		ukey_reg == frps_pkg::UK_HALF && ctrl_wr |=>
			ukey_reg == frps_pkg::UK_NONE)
		else $error("Half unlock survived a control write.");

endmodule : frps_sequencer

/* File: dv/frps_flash_model.sv */
// Behavioural flash array seen from the sequencer's flash-side outputs.
// Assumes the same clock as the sequencer; counts never reset.
`timescale 1ns/1ps
module frps_flash_model (
	input  wire logic        clk_i,
	input  wire logic        erase_i,
	input  wire logic        wvalid_i,
	input  wire logic [23:0] addr_i,
	input  wire logic [23:0] data_i
);
	int          words = 0;
	int          erases = 0;
	logic        er_reg = 1'b0;
	logic        wv_reg = 1'b0;
	logic [23:0] erase_addr;
	logic [23:0] first_addr;
	logic [23:0] last_addr;
	logic [23:0] last_data;
	// Stores each erase start and the ends of each burst of word writes.
	always @(posedge clk_i) begin
		er_reg <= erase_i;
		wv_reg <= wvalid_i;
		if (erase_i && !er_reg) begin
			erases++;
			erase_addr <= addr_i;
		end
		if (wvalid_i) begin
			words++;
			last_addr <= addr_i;
			last_data <= data_i;
			if (!wv_reg) first_addr <= addr_i;
		end
	end
endmodule : frps_flash_model

/* File: dv/flash_row_program_sequencer_bench.sv */
// Bench for the sequencer: register tasks over the bus and timed ops.
// Assumes shortened cycle lengths so each timed erase or program phase lasts eight cycles.
`timescale 1ns/1ps
module flash_row_program_sequencer_bench;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic [7:0]  aw_a = 8'h00;
	logic        aw_v = 1'b0;
	logic [31:0] w_d = 32'h0000_0000;
	logic        w_v = 1'b0;
	logic        b_rdy = 1'b0;
	logic [7:0]  ar_a = 8'h00;
	logic        ar_v = 1'b0;
	logic        r_rdy = 1'b0;
	logic        aw_r, w_r, b_v, ar_r, r_v, f_er, f_pg, f_wv, stall;
	logic [1:0]  b_resp, r_resp, last_b, last_r;
	logic [31:0] r_data, rv;
	logic [23:0] f_ad, f_da;
	logic [15:0] s;
	int          fails = 0;
	int          compares = 0;
	int          w0;
	frps_sequencer #(.PAGE_CYCLES(8), .ROW_CYCLES(8), .WORD_CYCLES(8))
	i_frps_sequencer (.clk_i(clk_i), .rst_i(rst_i), .s_axi_awaddr_i(aw_a),
		.s_axi_awvalid_i(aw_v), .s_axi_awready_o(aw_r),
		.s_axi_wdata_i(w_d), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(w_v),
		.s_axi_wready_o(w_r), .s_axi_bresp_o(b_resp), .s_axi_bvalid_o(b_v),
		.s_axi_bready_i(b_rdy), .s_axi_araddr_i(ar_a),
		.s_axi_arvalid_i(ar_v), .s_axi_arready_o(ar_r),
		.s_axi_rdata_o(r_data), .s_axi_rresp_o(r_resp),
		.s_axi_rvalid_o(r_v), .s_axi_rready_i(r_rdy), .flash_erase_o(f_er),
		.flash_prog_o(f_pg), .flash_wvalid_o(f_wv), .flash_addr_o(f_ad),
		.flash_data_o(f_da), .core_stall_o(stall));
	frps_flash_model i_frps_flash_model (.clk_i(clk_i), .erase_i(f_er),
		.wvalid_i(f_wv), .addr_i(f_ad), .data_i(f_da));
	// Free-running 200 MHz clock.
	always #2.5 clk_i = ~clk_i;
	task automatic conclude();
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : conclude
	task automatic chk(input logic [31:0] got, input logic [31:0] exp,
			input string what);
		compares++;
		if (got !== exp) begin
			fails++;
			$display("mismatch at %0t: %s", $time, what);
		end
	endtask : chk
	// One bus write; each channel is released at the edge it is taken.
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		int n;
		logic fin;
		n = 0;
		fin = 1'b0;
		aw_a <= a;
		w_d <= {16'h0000, d};
		aw_v <= 1'b1;
		w_v <= 1'b1;
		b_rdy <= 1'b1;
		while (!fin && n < 100) begin
			@(posedge clk_i);
			n++;
			if (aw_r) aw_v <= 1'b0;
			if (w_r) w_v <= 1'b0;
			if (b_v) begin
				last_b = b_resp;
				b_rdy <= 1'b0;
				fin = 1'b1;
			end
		end
		chk(32'(fin), 32'h0000_0001, "write timeout");
		if (!fin) begin
			conclude();
		end else begin
			// One edge passes so bready is never dropped and raised at once.
			@(posedge clk_i);
		end
	endtask : wr
	// One bus read, returning data and keeping the response code.
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		int n;
		logic fin;
		n = 0;
		fin = 1'b0;
		ar_a <= a;
		ar_v <= 1'b1;
		r_rdy <= 1'b1;
		while (!fin && n < 100) begin
			@(posedge clk_i);
			n++;
			if (ar_r) ar_v <= 1'b0;
			if (r_v) begin
				d = r_data;
				last_r = r_resp;
				r_rdy <= 1'b0;
				fin = 1'b1;
			end
		end
		chk(32'(fin), 32'h0000_0001, "read timeout");
		if (!fin) begin
			conclude();
		end else begin
			@(posedge clk_i);
		end
	endtask : rd
	// Polls the busy bit until the cycle ends, then checks the array rests.
	task automatic idle();
		int n;
		rv = 32'h0000_0001;
		for (n = 0; n < 200 && rv[0] !== 1'b0; n++) rd(frps_pkg::OFS_STAT, rv);
		chk(32'(n < 200), 32'h0000_0001, "busy timeout");
		if (n >= 200) begin
			conclude();
		end else begin
			chk({29'h0, stall, f_er, f_pg}, 32'h0000_0000, "idle");
		end
	endtask : idle
	// keys and start back to back, then a program cycle.
	task automatic run(input logic [15:0] c);
		wr(frps_pkg::OFS_KEY, 16'h0055);
		wr(frps_pkg::OFS_KEY, 16'h00AA);
		wr(frps_pkg::OFS_CTRL, c);
		// two idle cycles after the start write.
		repeat (2) @(posedge clk_i);
		chk({29'h0, stall, f_er, f_pg}, {29'h1, c[6], !c[6]}, "busy");
		idle();
	endtask : run
	// Main sequence of tests.
	initial begin
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		rd(frps_pkg::OFS_CTRL, rv);
		chk(rv, 32'h0000_0000, "ctrl reset value");
		wr(frps_pkg::OFS_CTRL, 16'hC042);
		rd(frps_pkg::OFS_CTRL, rv);
		chk(rv, 32'h0000_6042, "start without keys");
		wr(8'h1C, 16'h1234);
		rd(8'h1C, rv);
		chk({28'h0, last_b, last_r}, 32'h0000_000A, "unmapped response");
		$display("test reset and refusal done");
		// page address latched by a table write.
		wr(frps_pkg::OFS_PAGE, 16'h0001);
		wr(frps_pkg::OFS_PTR, 16'h0420);
		wr(frps_pkg::OFS_TLO, 16'h0000);
		wr(frps_pkg::OFS_CTRL, 16'h4042);
		wr(frps_pkg::OFS_KEY, 16'h0055);
		wr(frps_pkg::OFS_KEY, 16'h00AA);
		wr(frps_pkg::OFS_CTRL, 16'hC042);
		chk({31'h0, stall}, 32'h0000_0001, "stall during erase");
		idle();
		chk(i_frps_flash_model.erases, 1, "erase count");
		chk({8'h0, i_frps_flash_model.erase_addr}, 32'h0001_0400, "erase addr");
		rd(frps_pkg::OFS_CTRL, rv);
		chk(rv, 32'h0000_4042, "start cleared");
		$display("test page erase done");
		// merged page written back row by row.
		wr(frps_pkg::OFS_CTRL, 16'h4001);
		for (int r = 0; r < 8; r++) begin
			for (int i = 0; i < 64; i++) begin
				wr(frps_pkg::OFS_PTR, 16'h0400 + 16'(128 * r + 2 * i));
				wr(frps_pkg::OFS_TLO, 16'hA000 + 16'(64 * r + i));
				wr(frps_pkg::OFS_THI, 16'(i));
			end
			run(16'hC001);
			chk(i_frps_flash_model.words, 64 * (r + 1), "row words");
			chk({8'h0, i_frps_flash_model.first_addr},
				32'h0001_0400 + 32'(128 * r), "row first");
			chk({8'h0, i_frps_flash_model.last_addr},
				32'h0001_047E + 32'(128 * r), "row last");
			chk({8'h0, i_frps_flash_model.last_data},
				32'h003F_A03F + 32'(64 * r), "row data");
		end
		$display("test row program done");
		wr(frps_pkg::OFS_PTR, 16'h0404);
		wr(frps_pkg::OFS_TLO, 16'hBEEF);
		wr(frps_pkg::OFS_CTRL, 16'h4003);
		run(16'hC003);
		chk(i_frps_flash_model.words, 513, "word count");
		chk({8'h0, i_frps_flash_model.last_addr}, 32'h0001_0404, "word addr");
		chk({8'h0, i_frps_flash_model.last_data}, 32'h0002_BEEF, "word data");
		$display("test word program done");
		// refused starts set the error flag.
		for (int k = 0; k < 3; k++) begin
			s = (k == 0) ? 16'h0001 : 16'h4001;
			w0 = i_frps_flash_model.words;
			wr(frps_pkg::OFS_CTRL, s);
			wr(frps_pkg::OFS_KEY, 16'h0055);
			if (k == 1) wr(frps_pkg::OFS_KEY, 16'h0012);
			if (k == 2) wr(frps_pkg::OFS_CTRL, s);
			wr(frps_pkg::OFS_KEY, 16'h00AA);
			wr(frps_pkg::OFS_CTRL, s | 16'h8000);
			rd(frps_pkg::OFS_CTRL, rv);
			chk(rv, {16'h0000, s | 16'h2000}, "refused start");
			chk(i_frps_flash_model.words, w0, "no write");
		end
		$display("test refused starts done");
		conclude();
	end
endmodule : flash_row_program_sequencer_bench
